//--- core/eqs_pkg.sv
// Package with register map, field layout and reset values of the equalizer control bank
`default_nettype none
package eqs_pkg;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int FRM_RW_BIT = 15;
    localparam int FRM_ADDR_HI = 14;
    localparam int FRM_ADDR_LO = 8;
    // Register offsets
    localparam logic [6:0] OFS_GEN = 7'h00;
    localparam logic [6:0] OFS_DRV = 7'h01;
    localparam logic [6:0] OFS_LAUNCH = 7'h02;
    // General control fields
    localparam int GEN_CARRIER = 7;
    localparam int GEN_MUTE = 6;
    localparam int GEN_BYPASS = 5;
    localparam int GEN_SLEEP_HI = 4;
    localparam int GEN_SLEEP_LO = 3;
    localparam int GEN_MASTER_RST = 1;
    localparam int GEN_ACQ_RST = 0;
    // Sleep encodings
    localparam logic [1:0] SLEEP_NEVER = 2'h0;
    localparam logic [1:0] SLEEP_AUTO = 2'h1;
    localparam logic [1:0] SLEEP_FORCE = 2'h2;
    // Output driver fields
    localparam int DRV_SWING_HI = 7;
    localparam int DRV_SWING_LO = 6;
    localparam int DRV_OFS_HI = 5;
    localparam int DRV_OFS_LO = 4;
    localparam int DRV_DEEMPH_EN = 3;
    localparam int DRV_LEVEL_HI = 2;
    localparam int DRV_LEVEL_LO = 1;
    // Launch amplitude field
    localparam int LAUNCH_OPT = 7;
    // Reset values
    localparam logic RST_MUTE = 1'b0;
    localparam logic RST_BYPASS = 1'b0;
    localparam logic [1:0] RST_SLEEP = SLEEP_AUTO;
    localparam logic [7:0] RST_DRV = 8'ha2;
    localparam logic [7:0] RST_LAUNCH = 8'h00;
endpackage
`default_nettype wire

//--- core/eqs_spi_regs.sv
// SPI control register bank of the cable equalizer, with daisy-chain pass-through
//
// Behaviour
// RULE1: General control bit 7 reads back the sensed input carrier, read only.
// RULE2: Bit 6 mutes, bit 5 bypasses; mute beats bypass; both reset to zero.
// RULE3: A powered-down sleep state overrides both mute and bypass.
// RULE4: Sleep 00 always on, 01 sleep without input, 10 forced off, 11 reserved.
// RULE5: Host always writes zero into general control bit 2.
// RULE6: Writing bit 1 restores all registers and resets the state machine; self-clears.
// RULE7: Writing bit 0 resets only the acquisition state machine; self-clears.
// RULE8: Driver bits 7:6 pick swing 400/600/700/800 mV; reset 10.
// RULE9: Driver bits 5:4 pick common mode 0.8/1.0/1.2 V or supply; reset 10.
// RULE10: Driver bit 3 enables de-emphasis; reset zero.
// RULE11: Driver bits 2:1 pick de-emphasis depth, reset 01; bit 0 reads only.
// RULE12: Launch bit 7 selects nominal launch or 6 dB attenuated input; reset zero.
// RULE13: Writes leave read-only bits unchanged while writable fields update.
// RULE14: Frame is sixteen bits: read flag, seven address bits, eight data bits.
// RULE15: A write commits only when select rises after a full frame.
// RULE16: A read frame loads the byte that leaves during the dummy frame's last eight bits.
// RULE17: Frames pass from serial input to serial output as a sixteen-bit shift stage.
`default_nettype none
module eqs_spi_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial port pins
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    // Analog status
    input wire logic carrier_in,
    // Equalizer controls
    output logic mute_out,
    output logic bypass_out,
    output logic power_down,
    output logic acq_reset,
    output logic [1:0] swing_sel,
    output logic [1:0] cm_sel,
    output logic deemph_en,
    output logic [1:0] deemph_level,
    output logic launch_opt
);
    import eqs_pkg::*;

    localparam int NPIN = 4;
    localparam int P_SCK = 0;
    localparam int P_SS = 1;
    localparam int P_MOSI = 2;
    localparam int P_CAR = 3;
    // Idle pin levels: select high, clock, data and carrier low
    localparam logic [NPIN-1:0] PIN_IDLE = 4'h2;

    logic [NPIN-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic full_r, full_nxt;
    logic miso_r, miso_nxt;
    logic mute_r, mute_nxt, bypass_r, bypass_nxt;
    logic [1:0] sleep_r, sleep_nxt;
    logic [7:1] drv_r, drv_nxt;
    logic [7:0] launch_r, launch_nxt;
    logic mute_o_r, mute_o_nxt, byp_o_r, byp_o_nxt, pd_r, pd_nxt;
    logic acq_r, acq_nxt;
    logic sck_rise, sck_fall, ss_fall, ss_rise, sel, commit;
    logic [6:0] addr;

    // Readback of one register; unmapped addresses read as zero
    function automatic logic [7:0] read_reg(input logic [6:0] a, input logic car,
                                            input logic mu, input logic by,
                                            input logic [1:0] sl, input logic [7:1] dr,
                                            input logic [7:0] la);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFS_GEN:
            begin
                v[GEN_CARRIER] = car;
                v[GEN_MUTE] = mu;
                v[GEN_BYPASS] = by;
                v[GEN_SLEEP_HI:GEN_SLEEP_LO] = sl;
            end
            OFS_DRV: v = {dr, 1'b0};
            OFS_LAUNCH: v = la;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Pins are async to clk; a level is taken once the second and third stages agree
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
        begin
            flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
        end
    end

    always_comb
    begin
        sel = ~flt_r[P_SS] & ~flt_nxt[P_SS];
        sck_rise = sel & ~flt_r[P_SCK] & flt_nxt[P_SCK];
        sck_fall = sel & flt_r[P_SCK] & ~flt_nxt[P_SCK];
        ss_fall = flt_r[P_SS] & ~flt_nxt[P_SS];
        ss_rise = ~flt_r[P_SS] & flt_nxt[P_SS];
        // Only whole multiples of sixteen bits are accepted
        commit = ss_rise & full_r & (cnt_r == 4'h0); // RULE15
        addr = shift_r[FRM_ADDR_HI:FRM_ADDR_LO]; // RULE14
    end

    always_comb
    begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        full_nxt = full_r;
        miso_nxt = miso_r;
        mute_nxt = mute_r;
        bypass_nxt = bypass_r;
        sleep_nxt = sleep_r;
        drv_nxt = drv_r;
        launch_nxt = launch_r;
        acq_nxt = 1'b0;
        if (ss_fall)
        begin
            cnt_nxt = 4'h0;
            full_nxt = 1'b0;
            miso_nxt = shift_r[FRAME_BITS-1]; // RULE17
        end
        if (sck_rise)
        begin
            shift_nxt = {shift_r[FRAME_BITS-2:0], flt_nxt[P_MOSI]}; // RULE17
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'hf)
            begin
                full_nxt = 1'b1;
            end
        end
        if (sck_fall)
        begin
            miso_nxt = shift_r[FRAME_BITS-1]; // RULE17
        end
        if (commit && shift_r[FRM_RW_BIT])
        begin
            // Read: the byte replaces the data field and leaves in the next frame's tail
            shift_nxt[7:0] = read_reg(addr, flt_r[P_CAR], mute_r, bypass_r, sleep_r,
                                      drv_r, launch_r); // RULE16 RULE1
        end
        else if (commit)
        begin
            unique case (addr)
                OFS_GEN:
                begin
                    if (shift_r[GEN_MASTER_RST])
                    begin
                        // Written field values are dropped in favour of defaults
                        mute_nxt = RST_MUTE; // RULE6
                        bypass_nxt = RST_BYPASS;
                        sleep_nxt = RST_SLEEP;
                        drv_nxt = RST_DRV[7:1];
                        launch_nxt = RST_LAUNCH;
                        acq_nxt = 1'b1;
                    end
                    else
                    begin
                        // Carrier and reserved bit 2 are not stored
                        mute_nxt = shift_r[GEN_MUTE]; // RULE2 RULE13 RULE5
                        bypass_nxt = shift_r[GEN_BYPASS]; // RULE2
                        sleep_nxt = shift_r[GEN_SLEEP_HI:GEN_SLEEP_LO]; // RULE4
                        acq_nxt = shift_r[GEN_ACQ_RST]; // RULE7
                    end
                end
                OFS_DRV: drv_nxt = shift_r[7:1]; // RULE8 RULE9 RULE10 RULE11 RULE13
                OFS_LAUNCH: launch_nxt = shift_r[7:0]; // RULE12
                default: ;
            endcase
        end
    end

    // Effective controls; code 11 is treated as always enabled
    always_comb
    begin
        pd_nxt = (sleep_r == SLEEP_FORCE) ||
                 (sleep_r == SLEEP_AUTO && !flt_r[P_CAR]); // RULE4
        mute_o_nxt = !pd_nxt && mute_r; // RULE3
        byp_o_nxt = !pd_nxt && !mute_r && bypass_r; // RULE2 RULE3
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // All stages start at idle so no false select edge follows reset
            s1_r <= PIN_IDLE;
            s2_r <= PIN_IDLE;
            s3_r <= PIN_IDLE;
            flt_r <= PIN_IDLE;
            shift_r <= '0;
            cnt_r <= 4'h0;
            full_r <= 1'b0;
            miso_r <= 1'b0;
            mute_r <= RST_MUTE;
            bypass_r <= RST_BYPASS;
            sleep_r <= RST_SLEEP;
            drv_r <= RST_DRV[7:1];
            launch_r <= RST_LAUNCH;
            mute_o_r <= 1'b0;
            byp_o_r <= 1'b0;
            pd_r <= 1'b0;
            acq_r <= 1'b0;
        end
        else
        begin
            s1_r <= {carrier_in, mosi, ss_n, sck};
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
            miso_r <= miso_nxt;
            mute_r <= mute_nxt;
            bypass_r <= bypass_nxt;
            sleep_r <= sleep_nxt;
            drv_r <= drv_nxt;
            launch_r <= launch_nxt;
            mute_o_r <= mute_o_nxt;
            byp_o_r <= byp_o_nxt;
            pd_r <= pd_nxt;
            acq_r <= acq_nxt;
        end
    end

    assign miso = miso_r;
    assign mute_out = mute_o_r;
    assign bypass_out = byp_o_r;
    assign power_down = pd_r;
    assign acq_reset = acq_r;
    assign swing_sel = drv_r[DRV_SWING_HI:DRV_SWING_LO];
    assign cm_sel = drv_r[DRV_OFS_HI:DRV_OFS_LO];
    assign deemph_en = drv_r[DRV_DEEMPH_EN];
    assign deemph_level = drv_r[DRV_LEVEL_HI:DRV_LEVEL_LO];
    assign launch_opt = launch_r[LAUNCH_OPT];

    chk_mute_wins: assert property (@(posedge clk) disable iff (rst) // RULE2
        !(mute_out && bypass_out)) else $error("mute and bypass both active");
    chk_sleep_overrides: assert property (@(posedge clk) disable iff (rst) // RULE3
        power_down |-> !mute_out && !bypass_out) else $error("sleep did not override");
    chk_force_sleep: assert property (@(posedge clk) disable iff (rst) // RULE4
        sleep_r == SLEEP_FORCE |=> power_down) else $error("forced sleep not applied");
    chk_never_sleep: assert property (@(posedge clk) disable iff (rst) // RULE4
        sleep_r == SLEEP_NEVER |=> !power_down) else $error("sleep while disabled");
    chk_drv_commit: assert property (@(posedge clk) disable iff (rst) // RULE15
        commit && !shift_r[FRM_RW_BIT] && addr == OFS_DRV
        |=> drv_r == $past(shift_r[7:1])) else $error("driver write not committed");
    chk_no_midframe: assert property (@(posedge clk) disable iff (rst) // RULE15
        sel |=> $stable(drv_r) && $stable(launch_r)) else $error("write inside frame");
    chk_master_clear: assert property (@(posedge clk) disable iff (rst) // RULE6
        commit && !shift_r[FRM_RW_BIT] && addr == OFS_GEN && shift_r[GEN_MASTER_RST]
        |=> drv_r == RST_DRV[7:1] && sleep_r == RST_SLEEP && acq_reset)
        else $error("master reset incomplete");
    chk_acq_pulse: assert property (@(posedge clk) disable iff (rst) // RULE7
        acq_reset |=> !acq_reset) else $error("acquisition reset not self-clearing");
    chk_carrier_read: assert property (@(posedge clk) disable iff (rst) // RULE1
        commit && shift_r[FRM_RW_BIT] && addr == OFS_GEN
        |=> shift_r[GEN_CARRIER] == $past(flt_r[P_CAR])) else $error("carrier readback wrong");
    chk_miso_shift: assert property (@(posedge clk) disable iff (rst) // RULE17
        sck_fall |=> miso == $past(shift_r[FRAME_BITS-1])) else $error("serial out mismatch");
endmodule
`default_nettype wire

//--- tb/eqs_host.sv
// SPI host model that frames, shifts and captures the control port
`default_nettype none
module eqs_host
(
    // Clock
    input wire logic clk,
    // Serial port
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Mode 0: data changes with sck low, 80 ns half period keeps the 3-flop filter happy
    task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        ss_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            mosi = tx[i];
            step(20);
            sck = 1'b1;
            rx[i] = miso;
            step(20);
            sck = 1'b0;
        end
        step(20);
        ss_n = 1'b1;
        mosi = ~mosi;
        step(24);
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the equalizer SPI control bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import eqs_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic carrier_in = 1'b0;
    wire logic sck, ss_n, mosi, miso;
    logic mute_out, bypass_out, power_down, acq_reset, deemph_en, launch_opt;
    logic [1:0] swing_sel, cm_sel, deemph_level;
    int failures = 0;
    int tests_run = 0;
    int acq_cnt = 0;
    int n;
    logic [7:0] d;
    logic [31:0] junk;

    always #2 clk = ~clk;

    always @(posedge clk)
        if (acq_reset === 1'b1)
            acq_cnt <= acq_cnt + 1;

    eqs_spi_regs uut (.clk(clk), .rst(rst), .sck(sck), .ss_n(ss_n), .mosi(mosi),
        .miso(miso), .carrier_in(carrier_in), .mute_out(mute_out),
        .bypass_out(bypass_out), .power_down(power_down), .acq_reset(acq_reset),
        .swing_sel(swing_sel), .cm_sel(cm_sel), .deemph_en(deemph_en),
        .deemph_level(deemph_level), .launch_opt(launch_opt));

    eqs_host host (.clk(clk), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Low byte mirrors the driver register layout, launch option in bit 0
    function automatic logic [15:0] outs();
        return {5'h0, mute_out, bypass_out, power_down, swing_sel, cm_sel, deemph_en,
            deemph_level, launch_opt};
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [31:0] rx;
        host.shift(16, {16'h0, 1'b0, a, v}, rx);
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [31:0] rx;
        host.shift(16, {16'h0, 1'b1, a, 8'hff}, rx);
        host.shift(16, 32'h0000ffff, rx);
        check(rx[15:0], {1'b1, a, exp});
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end

    initial
    begin
        host.step(10);
        rst = 1'b0;
        host.step(10);
        check(outs(), 16'h01a2);
        rdchk(OFS_GEN, 8'h08);
        rdchk(OFS_DRV, 8'ha2);
        rdchk(OFS_LAUNCH, 8'h00);
        rdchk(7'h33, 8'h00);
        $display("Reset values test done");
        for (int i = 0; i < 4; i++)
        begin
            d = {i[1:0], i[1:0], i[0], i[1:0], 1'b1};
            wr(OFS_DRV, d);
            check(outs(), {8'h01, d[7:1], 1'b0});
            rdchk(OFS_DRV, d & 8'hfe);
        end
        wr(OFS_LAUNCH, 8'h80);
        check({15'h0, launch_opt}, 16'h0001);
        host.shift(24, {8'h0, 8'hff, 1'b0, OFS_LAUNCH, 8'h00}, junk);
        rdchk(OFS_LAUNCH, 8'h80);
        $display("Driver and launch test done");
        carrier_in = 1'b1;
        host.step(10);
        rdchk(OFS_GEN, 8'h88);
        check(outs(), 16'h00ff);
        wr(OFS_GEN, 8'h60);
        check(outs(), 16'h04ff);
        wr(OFS_GEN, 8'h20);
        check(outs(), 16'h02ff);
        wr(OFS_GEN, 8'h70);
        check(outs(), 16'h01ff);
        wr(OFS_GEN, 8'h68);
        check(outs(), 16'h04ff);
        carrier_in = 1'b0;
        host.step(10);
        check(outs(), 16'h01ff);
        wr(OFS_GEN, 8'h18);
        check(outs(), 16'h00ff);
        wr(OFS_GEN, 8'h00);
        check(outs(), 16'h00ff);
        wr(OFS_GEN, 8'hc8);
        rdchk(OFS_GEN, 8'h48);
        $display("Power and mute test done");
        n = acq_cnt;
        wr(OFS_GEN, 8'h49);
        check(16'(acq_cnt - n), 16'h0001);
        rdchk(OFS_GEN, 8'h48);
        wr(OFS_GEN, 8'h02);
        check(16'(acq_cnt - n), 16'h0002);
        rdchk(OFS_GEN, 8'h08);
        rdchk(OFS_DRV, 8'ha2);
        rdchk(OFS_LAUNCH, 8'h00);
        $display("Self-clearing reset test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
